// ### src/dacw_cfg.svh
`ifndef DACW_CFG_SVH
`define DACW_CFG_SVH

// Timing base.
`define DACW_CLK_NS 100
`define DACW_SCL_NS 10000
`define DACW_QTR_CYC ((`DACW_SCL_NS) / (4 * `DACW_CLK_NS))
`define DACW_WAKE_NS 2500
`define DACW_WAKE_CYC ((`DACW_WAKE_NS + `DACW_CLK_NS - 1) / `DACW_CLK_NS)

// Addressing. The device prefix value is arbitrary.
`define DACW_DEV_PREFIX 6'h2B
`define DACW_BCAST_ADDR 8'h90
`define DACW_WRITE_BIT 1'h0

// Control/high byte field positions.
`define DACW_HI_MODE_MSB 5
`define DACW_HI_MODE_LSB 4
`define DACW_HI_CODE_MSB 3

// Reset values of the device shadow.
`define DACW_CODE_RST 12'h000
`define DACW_MODE_NORMAL 2'h0

`endif

// ### src/dacw_master.sv
`timescale 1ns/10ps
`include "dacw_cfg.svh"

module dacw_master
	import dacw_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire dacw_cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	output logic nack_err,
	output logic busy,
	output dacw_shadow_t shadow,
	output logic out_valid,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	dacw_state_t state_q;
	logic [1:0] ph_q;
	logic [4:0] tick_q;
	logic [3:0] bitn_q;
	logic [1:0] byte_q;
	logic [7:0] shift_q;
	dacw_cmd_t cur_q;
	logic ack_q;
	logic sda_m_q;
	logic sda_s_q;
	logic [4:0] wake_q;
	logic tick_end;
	logic pair_done;

	assign tick_end = (tick_q == 5'h00);
	assign pair_done = (state_q == DACW_BIT) && tick_end && (ph_q == 2'h3)
		&& (bitn_q == 4'h8) && (byte_q == 2'h2) && ack_q;

	function automatic logic [7:0] addr_byte(input dacw_cmd_t c);
		return c.bcast ? `DACW_BCAST_ADDR
			: {`DACW_DEV_PREFIX, c.dev_sel, `DACW_WRITE_BIT};
	endfunction : addr_byte

	function automatic logic [7:0] hi_byte(input dacw_cmd_t c);
		return {2'h0, c.pwr_mode, c.code[11:8]};
	endfunction : hi_byte

	// The data line comes straight off the bus, so it is resynchronised first.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sda_m_q <= 1'h1;
			sda_s_q <= 1'h1;
		end
		else
		begin
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	// Quarter-period timer; every bus phase lasts one quarter of the SCL period.
	always_ff @(posedge mclk)
	begin
		tick_q <= (reset || state_q == DACW_IDLE || state_q == DACW_DECIDE || tick_end)
			? 5'(`DACW_QTR_CYC - 1) : tick_q - 5'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= DACW_IDLE;
			ph_q <= 2'h0;
			bitn_q <= 4'h0;
			byte_q <= 2'h0;
			shift_q <= 8'h00;
			cur_q <= '0;
			ack_q <= 1'h0;
			cmd_ready <= 1'h1;
			done <= 1'h0;
			nack_err <= 1'h0;
		end
		else
		begin
			done <= 1'h0;
			nack_err <= 1'h0;
			case (state_q)
				DACW_IDLE:
				begin
					if (cmd_valid && cmd_ready)
					begin
						cur_q <= cmd;
						shift_q <= addr_byte(cmd);
						byte_q <= 2'h0;
						ph_q <= 2'h0;
						cmd_ready <= 1'h0;
						state_q <= DACW_START;
					end
				end
				DACW_START:
				begin
					if (tick_end)
					begin
						ph_q <= ph_q + 2'h1;
						if (ph_q == 2'h3)
						begin
							bitn_q <= 4'h0;
							state_q <= DACW_BIT;
						end
					end
				end
				DACW_BIT:
				begin
					if (tick_end)
					begin
						ph_q <= ph_q + 2'h1;
						ack_q <= (ph_q == 2'h2 && bitn_q == 4'h8) ? ~sda_s_q : ack_q;
						if (ph_q == 2'h3 && bitn_q != 4'h8)
						begin
							shift_q <= {shift_q[6:0], 1'h0};
							bitn_q <= bitn_q + 4'h1;
						end
						else if (ph_q == 2'h3)
						begin
							bitn_q <= 4'h0;
							if (!ack_q)
							begin
								nack_err <= 1'h1;
								state_q <= DACW_STOP;
							end
							else if (byte_q == 2'h2)
							begin
								done <= 1'h1;
								cmd_ready <= 1'h1;
								state_q <= DACW_DECIDE;
							end
							else if (byte_q == 2'h1)
							begin
								shift_q <= cur_q.code[7:0];
								byte_q <= 2'h2;
							end
							else
							begin
								shift_q <= hi_byte(cur_q);
								byte_q <= 2'h1;
							end
						end
					end
				end
				DACW_DECIDE:
				begin
					cmd_ready <= 1'h0;
					ph_q <= 2'h0;
					if (cmd_valid && cmd.bcast == cur_q.bcast && cmd.dev_sel == cur_q.dev_sel)
					begin
						cur_q <= cmd;
						shift_q <= hi_byte(cmd);
						byte_q <= 2'h1;
						state_q <= DACW_BIT;
					end
					else if (cmd_valid)
					begin
						cur_q <= cmd;
						shift_q <= addr_byte(cmd);
						byte_q <= 2'h0;
						state_q <= DACW_START;
					end
					else
					begin
						state_q <= DACW_STOP;
					end
				end
				DACW_STOP:
				begin
					if (tick_end)
					begin
						ph_q <= ph_q + 2'h1;
						if (ph_q == 2'h3)
						begin
							cmd_ready <= 1'h1;
							state_q <= DACW_IDLE;
						end
					end
				end
				default:
				begin
					state_q <= DACW_IDLE;
				end
			endcase
		end
	end

	// Pin drivers. Both lines are open drain: enable means pull low.
	always_ff @(posedge mclk)
	begin
		scl_o <= 1'h0;
		sda_o <= 1'h0;
		if (reset)
		begin
			scl_oe <= 1'h0;
			sda_oe <= 1'h0;
		end
		else
		begin
			case (state_q)
				DACW_START:
				begin
					// A repeated start arrives with the clock low, so data is
					// released before the clock rises.
					scl_oe <= (ph_q == 2'h0) ? scl_oe : (ph_q == 2'h3);
					sda_oe <= (ph_q >= 2'h2);
				end
				DACW_BIT:
				begin
					scl_oe <= (ph_q == 2'h0) || (ph_q == 2'h3);
					if (ph_q == 2'h0)
					begin
						sda_oe <= (bitn_q == 4'h8) ? 1'h0 : ~shift_q[7];
					end
				end
				DACW_STOP:
				begin
					scl_oe <= (ph_q == 2'h0);
					sda_oe <= (ph_q <= 2'h1);
				end
				default:
				begin
					scl_oe <= (state_q == DACW_IDLE) ? 1'h0 : scl_oe;
					sda_oe <= (state_q == DACW_IDLE) ? 1'h0 : sda_oe;
				end
			endcase
		end
	end

	// Shadow of what the converter holds, and its wake-up wait.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			shadow <= {`DACW_MODE_NORMAL, `DACW_CODE_RST};
			wake_q <= 5'h00;
			out_valid <= 1'h1;
			busy <= 1'h0;
		end
		else
		begin
			busy <= (state_q != DACW_IDLE);
			if (pair_done)
			begin
				shadow <= {cur_q.pwr_mode, cur_q.code};
				if (cur_q.pwr_mode == `DACW_MODE_NORMAL && shadow.pwr_mode != `DACW_MODE_NORMAL)
				begin
					wake_q <= 5'(`DACW_WAKE_CYC);
					out_valid <= 1'h0;
				end
				else
				begin
					out_valid <= (cur_q.pwr_mode == `DACW_MODE_NORMAL) && (wake_q == 5'h00);
				end
			end
			else if (wake_q != 5'h00)
			begin
				wake_q <= wake_q - 5'h01;
				out_valid <= (wake_q == 5'h01);
			end
		end
	end

endmodule : dacw_master

// ### src/dacw_pkg.sv
package dacw_pkg;

	typedef struct packed {
		logic bcast;
		logic dev_sel;
		logic [1:0] pwr_mode;
		logic [11:0] code;
	} dacw_cmd_t;

	typedef struct packed {
		logic [1:0] pwr_mode;
		logic [11:0] code;
	} dacw_shadow_t;

	typedef enum logic [2:0] {
		DACW_IDLE,
		DACW_START,
		DACW_BIT,
		DACW_DECIDE,
		DACW_STOP
	} dacw_state_t;

endpackage : dacw_pkg

// ### verif/dacw_dev.sv
`timescale 1ns/10ps
`include "dacw_cfg.svh"
module dacw_dev
	import dacw_pkg::*;
(
	input wire logic scl,
	input wire logic sda,
	input wire logic addr_select_pin,
	output logic pull,
	output dacw_shadow_t dev_q
);
	logic [7:0] sh;
	logic [7:0] hi;
	logic on = 1'b0;
	int n;
	int b;
	// Power-on is the only reset this device has.
	initial
	begin
		pull = 1'b0;
		dev_q = '0;
	end
	always @(negedge sda)
		if (scl)
		begin
			n = -1;
			b = 0;
			on = 1'b1;
		end
	always @(posedge sda)
		if (scl)
			on = 1'b0;
	always @(posedge scl)
		if (on && n < 8)
			sh = {sh[6:0], sda};
	always @(negedge scl)
		if (on)
		begin
			pull = 1'b0;
			n = n + 1;
			if (n == 8 && b == 0)
				on = sh == {`DACW_DEV_PREFIX, addr_select_pin, `DACW_WRITE_BIT}
					|| sh == `DACW_BCAST_ADDR;
			if (n == 8 && b == 1)
				hi = sh;
			if (n == 8)
				pull = on;
			if (n == 9)
			begin
				n = 0;
				if (b == 2)
					dev_q = {hi[5:4], hi[3:0], sh};
				b = (b == 2) ? 1 : b + 1;
			end
		end
endmodule : dacw_dev

// ### verif/dacw_master_props.sv
`timescale 1ns/10ps
module dacw_master_props
	import dacw_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic nack_err,
	input wire dacw_shadow_t shadow,
	input wire logic out_valid,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic busy,
	input wire logic scl_o,
	input wire logic sda_o
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	AST_DONE_ONE: assert property (done |=> !done) else $error("done");
	AST_NACK_ONE: assert property (nack_err |=> !nack_err) else $error("nack");
	AST_DONE_RDY: assert property (done |-> cmd_ready) else $error("rdy");
	AST_SHADOW: assert property ($changed(shadow) |-> done || $past(done)) else $error("shd");
	AST_PD: assert property (shadow.pwr_mode != 2'h0 && $stable(shadow) |-> !out_valid)
		else $error("pd");
	AST_WAKE: assert property ($past(shadow.pwr_mode) != 2'h0 && shadow.pwr_mode == 2'h0
		|-> ##[0:1] !out_valid ##[20:30] out_valid) else $error("wake");
	AST_START: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:30] scl_oe) else $error("st");
	AST_STOP: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe)
		|-> ##[40:60] cmd_ready) else $error("sp");
	AST_OD_LOW: assert property (!scl_o && !sda_o) else $error("od");
	AST_BUSY: assert property ((scl_oe || sda_oe) |-> busy) else $error("busy");
endmodule : dacw_master_props
bind dacw_master dacw_master_props u_props (.mclk, .reset, .cmd_ready, .done, .nack_err,
	.shadow, .out_valid, .scl_oe, .sda_oe, .busy, .scl_o, .sda_o);

// ### verif/tb.sv
`timescale 1ns/10ps
module tb import dacw_pkg::*;;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid = 1'b0;
	dacw_cmd_t cmd = '0;
	logic cmd_ready, done, nack_err, busy, out_valid, scl_oe, sda_oe, pull;
	dacw_shadow_t shadow;
	dacw_shadow_t dev_q;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || pull);
	logic sel = 1'b1;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #50 mclk = !mclk;
	dacw_master DUT (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .nack_err(nack_err), .busy(busy), .shadow(shadow),
		.out_valid(out_valid), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
	dacw_dev u_dev (.scl(scl), .sda(sda), .addr_select_pin(sel), .pull(pull), .dev_q(dev_q));
	task automatic close_out();
		$display("checks %0d fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input dacw_cmd_t c);
		@(posedge mclk);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge mclk iff cmd_ready === 1'b1);
	endtask : put
	task automatic fin(input logic okx, input logic ovx, input dacw_shadow_t e);
		logic ok;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		@(posedge mclk iff (done === 1'b1 || nack_err === 1'b1));
		ok = done;
		@(negedge mclk);
		chk({ok, out_valid, shadow, busy, 1'b0, dev_q}, {okx, ovx, e, 2'h2, e});
	endtask : fin
	task automatic t_modes();
		logic [11:0] k [4] = '{12'hFFF, 12'h800, 12'h001, 12'hA5C};
		dacw_shadow_t e;
		for (int i = 0; i < 4; i++)
		begin
			put({1'b0, sel, 2'(i + 1), k[i]});
			if (i > 0)
			begin
				@(negedge mclk);
				e = {2'(i), k[i - 1]};
				chk({2'h0, shadow, 2'h0, dev_q}, {2'h0, e, 2'h0, e});
			end
		end
		fin(1'b1, 1'b0, {2'h0, 12'hA5C});
		repeat (26) @(negedge mclk);
		chk({1'b0, out_valid, 30'h0}, 32'h40000000);
		$display("modes end");
	endtask : t_modes
	task automatic t_addr();
		put({1'b0, !sel, 2'h2, 12'h456});
		fin(1'b0, 1'b1, {2'h0, 12'hA5C});
		put({1'b1, !sel, 2'h0, 12'h123});
		put({1'b0, sel, 2'h0, 12'h3C7});
		@(negedge mclk);
		chk({2'h0, shadow, 2'h0, dev_q}, {4'h0, 12'h123, 4'h0, 12'h123});
		fin(1'b1, 1'b1, {2'h0, 12'h3C7});
		$display("addr end");
	endtask : t_addr
	initial
	begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		chk({cmd_ready, out_valid, shadow, busy, 1'b0, dev_q}, 32'hC0000000);
		t_modes();
		t_addr();
		close_out();
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fail_count++;
			close_out();
		end
	end
endmodule : tb
